// >>> design/nicer_pkg.sv
// package: offsets, fields, reset values and carriers of the early-rx / command / irq-mask group
package nicer_pkg;
	// byte offsets on the register port
	localparam logic [7:0] OFS_EARLY_RX_STATUS = 8'h36;
	localparam logic [7:0] OFS_COMMAND_CONTROL = 8'h37;
	localparam logic [7:0] OFS_IRQ_MASK_LO = 8'h3C;
	localparam logic [7:0] OFS_IRQ_MASK_HI = 8'h3D;
	localparam logic [7:0] OFS_IRQ_STATUS_LO = 8'h3E;
	localparam logic [7:0] OFS_IRQ_STATUS_HI = 8'h3F;

	// early receive status fields
	localparam int ERS_GOOD_BIT = 3;
	localparam int ERS_BAD_BIT = 2;
	localparam int ERS_COLLIDE_BIT = 1;
	localparam int ERS_THRESH_BIT = 0;

	// command fields
	localparam int CMD_SW_RESET_BIT = 4;
	localparam int CMD_RX_ENABLE_BIT = 3;
	localparam int CMD_TX_ENABLE_BIT = 2;
	localparam int CMD_RING_EMPTY_BIT = 0;

	// interrupt status / mask bit positions
	localparam int IRQ_SYS_FAULT = 15;
	localparam int IRQ_TIMER_TIMEOUT = 14;
	localparam int IRQ_CABLE_LEN = 13;
	localparam int IRQ_STATUS_FIFO_OVF = 6;
	localparam int IRQ_UNDERRUN_LINK = 5;
	localparam int IRQ_RING_OVERFLOW = 4;
	localparam int IRQ_TX_ERR = 3;
	localparam int IRQ_TX_OK = 2;
	localparam int IRQ_RX_FAULT = 1;
	localparam int IRQ_RX_GOOD = 0;
	localparam logic [15:0] IRQ_IMPL_MASK = 16'hE07F;

	// reset values
	localparam logic [3:0] ERS_RESET = 4'h0;
	localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
	localparam logic [15:0] IRQ_STATUS_RESET = 16'h0000;

	// software reset duration
	localparam int SW_RESET_NS = 160;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SW_RESET_CYCLES = (SW_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// one-cycle event strobes from the receive and transmit paths
	typedef struct packed {
		logic sys_fault_event;
		logic timer_timeout;
		logic cable_length_change;
		logic rx_status_fifo_overflow;
		logic underrun_or_link_change;
		logic rx_ring_overflow;
		logic tx_err_event;
		logic tx_ok_event;
		logic pkt_done_good;
		logic pkt_done_bad;
		logic ptr_collide;
	} nicer_evt_t;

	// control handed to the datapath
	typedef struct packed {
		logic sw_reset;
		logic rx_enable;
		logic tx_enable;
	} nicer_ctl_t;
endpackage : nicer_pkg

// >>> design/nicer_regs.sv
// module: early-rx status, command and interrupt mask/status registers with the interrupt line
`timescale 1ns/10ps

module nicer_regs #(
	parameter int CNT_W = 11,
	parameter int RST_CYCLES = nicer_pkg::SW_RESET_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rd_data,
	input wire nicer_pkg::nicer_evt_t i_evt,
	input wire logic [CNT_W-1:0] i_rx_byte_cnt,
	input wire logic [CNT_W-1:0] i_rx_threshold,
	input wire logic i_rx_in_packet,
	input wire logic i_rx_ring_empty,
	input wire logic i_rx_machine_idle,
	input wire logic i_tx_machine_idle,
	output nicer_pkg::nicer_ctl_t o_ctl,
	output logic o_irq
);

	localparam int RC_W = $clog2(RST_CYCLES + 1);
	localparam logic [RC_W-1:0] RC_LOAD = RC_W'(RST_CYCLES);

	// register state
	logic [3:0] ers_q;
	logic [3:0] ers_d;
	logic [15:0] imr_q;
	logic [15:0] isr_q;
	logic [15:0] isr_d;
	logic [7:0] isr_hi_hold_q;
	logic rx_on_q;
	logic tx_on_q;
	logic rst_busy_q;
	logic [RC_W-1:0] rst_cnt_q;
	logic [7:0] rd_data_q;
	logic irq_q;

	// decoded strobes
	logic wr_ers;
	logic wr_cmd;
	logic wr_imr_lo;
	logic wr_imr_hi;
	logic rd_isr_lo;
	logic thresh_cross;
	logic thresh_rise;
	logic [15:0] isr_set;

	// one address compare used by all five address strobes
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	assign wr_ers = i_wr && hit(i_addr, nicer_pkg::OFS_EARLY_RX_STATUS);
	assign wr_cmd = i_wr && hit(i_addr, nicer_pkg::OFS_COMMAND_CONTROL);
	assign wr_imr_lo = i_wr && hit(i_addr, nicer_pkg::OFS_IRQ_MASK_LO);
	assign wr_imr_hi = i_wr && hit(i_addr, nicer_pkg::OFS_IRQ_MASK_HI);
	// writes to the status offsets decode to nothing, so they have no effect
	assign rd_isr_lo = i_rd && hit(i_addr, nicer_pkg::OFS_IRQ_STATUS_LO);

	// byte count crossing the programmed threshold while a packet is arriving
	assign thresh_cross = i_rx_in_packet && (i_rx_byte_cnt > i_rx_threshold);
	// the flag only rises once per packet; completion takes priority over a crossing
	assign thresh_rise = thresh_cross && !ers_q[nicer_pkg::ERS_THRESH_BIT]
		&& !i_evt.pkt_done_good && !i_evt.pkt_done_bad;

	// early receive status next value: events win over the write-one clear
	always_comb begin
		ers_d = ers_q;
		if (wr_ers) begin
			ers_d[nicer_pkg::ERS_GOOD_BIT] = ers_q[nicer_pkg::ERS_GOOD_BIT]
				& ~i_wr_data[nicer_pkg::ERS_GOOD_BIT];
			ers_d[nicer_pkg::ERS_BAD_BIT] = ers_q[nicer_pkg::ERS_BAD_BIT]
				& ~i_wr_data[nicer_pkg::ERS_BAD_BIT];
			ers_d[nicer_pkg::ERS_COLLIDE_BIT] = ers_q[nicer_pkg::ERS_COLLIDE_BIT]
				& ~i_wr_data[nicer_pkg::ERS_COLLIDE_BIT];
		end
		if (i_evt.pkt_done_good) begin
			ers_d[nicer_pkg::ERS_GOOD_BIT] = 1'b1;
		end
		if (i_evt.pkt_done_bad) begin
			ers_d[nicer_pkg::ERS_BAD_BIT] = 1'b1;
		end
		if (i_evt.ptr_collide) begin
			ers_d[nicer_pkg::ERS_COLLIDE_BIT] = 1'b1;
		end
		// threshold flag is read-only to software; hardware sets and clears it
		if (i_evt.pkt_done_good || i_evt.pkt_done_bad) begin
			ers_d[nicer_pkg::ERS_THRESH_BIT] = 1'b0;
		end else if (thresh_rise) begin
			ers_d[nicer_pkg::ERS_THRESH_BIT] = 1'b1;
		end
		// during a software reset the receiver is down, so the threshold flag may not linger
		if (rst_busy_q) begin
			ers_d[nicer_pkg::ERS_THRESH_BIT] = 1'b0;
		end
	end

	// interrupt status sources, independent of the mask
	always_comb begin
		isr_set = 16'h0000;
		isr_set[nicer_pkg::IRQ_SYS_FAULT] = i_evt.sys_fault_event;
		isr_set[nicer_pkg::IRQ_TIMER_TIMEOUT] = i_evt.timer_timeout;
		isr_set[nicer_pkg::IRQ_CABLE_LEN] = i_evt.cable_length_change;
		isr_set[nicer_pkg::IRQ_STATUS_FIFO_OVF] = i_evt.rx_status_fifo_overflow;
		isr_set[nicer_pkg::IRQ_UNDERRUN_LINK] = i_evt.underrun_or_link_change;
		isr_set[nicer_pkg::IRQ_RING_OVERFLOW] = i_evt.rx_ring_overflow;
		isr_set[nicer_pkg::IRQ_TX_ERR] = i_evt.tx_err_event;
		isr_set[nicer_pkg::IRQ_TX_OK] = i_evt.tx_ok_event;
		isr_set[nicer_pkg::IRQ_RX_FAULT] = i_evt.pkt_done_bad;
		isr_set[nicer_pkg::IRQ_RX_GOOD] = i_evt.pkt_done_good || thresh_rise;
	end

	// read of the low status byte clears everything; a same-cycle event survives
	always_comb begin
		isr_d = isr_q;
		if (rd_isr_lo) begin
			isr_d = nicer_pkg::IRQ_STATUS_RESET;
		end
		isr_d = (isr_d | isr_set) & nicer_pkg::IRQ_IMPL_MASK;
	end

	// early receive status register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ers_q <= nicer_pkg::ERS_RESET;
		end else if (i_ce) begin
			ers_q <= ers_d;
		end
	end

	// interrupt status register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			isr_q <= nicer_pkg::IRQ_STATUS_RESET;
		end else if (i_ce) begin
			isr_q <= isr_d;
		end
	end

	// high status byte is frozen at the low-byte read, so a 2-byte read sees one snapshot
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			isr_hi_hold_q <= 8'h00;
		end else if (i_ce && rd_isr_lo) begin
			isr_hi_hold_q <= isr_q[15:8];
		end
	end

	// interrupt mask: only the bus reset clears it, a software reset leaves it
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			imr_q <= nicer_pkg::IRQ_MASK_RESET;
		end else if (i_ce) begin
			if (wr_imr_lo) begin
				imr_q[7:0] <= i_wr_data & nicer_pkg::IRQ_IMPL_MASK[7:0];
			end
			if (wr_imr_hi) begin
				imr_q[15:8] <= i_wr_data & nicer_pkg::IRQ_IMPL_MASK[15:8];
			end
		end
	end

	// software reset sequencer: bit reads one until the count runs out
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rst_busy_q <= 1'b0;
			rst_cnt_q <= '0;
		end else if (i_ce) begin
			if (rst_busy_q) begin
				if (rst_cnt_q == RC_W'(1)) begin
					rst_busy_q <= 1'b0;
				end
				rst_cnt_q <= rst_cnt_q - RC_W'(1);
			end else if (wr_cmd && i_wr_data[nicer_pkg::CMD_SW_RESET_BIT]) begin
				rst_busy_q <= 1'b1;
				rst_cnt_q <= RC_LOAD;
			end
		end
	end

	// receive machine activity: starts only from idle, stops on write of zero or reset
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_on_q <= 1'b0;
		end else if (i_ce) begin
			if (rst_busy_q || (wr_cmd && i_wr_data[nicer_pkg::CMD_SW_RESET_BIT])) begin
				rx_on_q <= 1'b0;
			end else if (wr_cmd) begin
				if (!i_wr_data[nicer_pkg::CMD_RX_ENABLE_BIT]) begin
					rx_on_q <= 1'b0;
				end else if (i_rx_machine_idle) begin
					rx_on_q <= 1'b1;
				end
			end
		end
	end

	// transmit machine activity, same shape as receive
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_on_q <= 1'b0;
		end else if (i_ce) begin
			if (rst_busy_q || (wr_cmd && i_wr_data[nicer_pkg::CMD_SW_RESET_BIT])) begin
				tx_on_q <= 1'b0;
			end else if (wr_cmd) begin
				if (!i_wr_data[nicer_pkg::CMD_TX_ENABLE_BIT]) begin
					tx_on_q <= 1'b0;
				end else if (i_tx_machine_idle) begin
					tx_on_q <= 1'b1;
				end
			end
		end
	end

	// read mux; data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_data_q <= 8'h00;
		end else if (i_ce) begin
			rd_data_q <= 8'h00;
			if (i_rd) begin
				unique case (i_addr)
					nicer_pkg::OFS_EARLY_RX_STATUS: rd_data_q <= {4'h0, ers_q};
					nicer_pkg::OFS_COMMAND_CONTROL: begin
						rd_data_q <= {3'h0, rst_busy_q, rx_on_q, tx_on_q, 1'b0,
							i_rx_ring_empty};
					end
					nicer_pkg::OFS_IRQ_MASK_LO: rd_data_q <= imr_q[7:0];
					nicer_pkg::OFS_IRQ_MASK_HI: rd_data_q <= imr_q[15:8];
					nicer_pkg::OFS_IRQ_STATUS_LO: rd_data_q <= isr_q[7:0];
					nicer_pkg::OFS_IRQ_STATUS_HI: rd_data_q <= isr_hi_hold_q;
					default: rd_data_q <= 8'h00;
				endcase
			end
		end
	end

	// interrupt line registered from status AND mask, one cycle behind the status
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_q <= 1'b0;
		end else if (i_ce) begin
			irq_q <= |(isr_q & imr_q);
		end
	end

	// datapath control; station address, filter and config live elsewhere and see none of this
	assign o_ctl.sw_reset = rst_busy_q;
	assign o_ctl.rx_enable = rx_on_q;
	assign o_ctl.tx_enable = tx_on_q;
	assign o_rd_data = rd_data_q;
	assign o_irq = irq_q;

endmodule : nicer_regs

// >>> test/nicer_chk_asserts.sv
// checker: port properties of the early-rx, command and irq-mask registers
`timescale 1ns/10ps
module nicer_chk #(
	parameter int RST_CYCLES = 16
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rd_data,
	input wire nicer_pkg::nicer_evt_t i_evt,
	input wire logic i_rx_machine_idle,
	input wire nicer_pkg::nicer_ctl_t o_ctl,
	input wire logic o_irq
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	logic [7:0] run_q;
	// reset pulse length so far; a counter avoids a long repetition
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			run_q <= 8'h00;
		else
			run_q <= o_ctl.sw_reset ? run_q + 8'h01 : 8'h00;
	end
	// an event followed soon by a read of the register that records it
	sequence s_evt_rd(logic ev, logic [7:0] a);
		ev ##[1:4] (i_rd && i_addr == a);
	endsequence
	sequence s_cmd;
		i_wr && i_addr == nicer_pkg::OFS_COMMAND_CONTROL;
	endsequence
	property p_good_sets;
		s_evt_rd(i_evt.pkt_done_good, nicer_pkg::OFS_EARLY_RX_STATUS) |=> o_rd_data[3];
	endproperty
	a_good_sets: assert property (p_good_sets) else $error("good flag not set");
	property p_collide_sets;
		s_evt_rd(i_evt.ptr_collide, nicer_pkg::OFS_EARLY_RX_STATUS) |=> o_rd_data[1];
	endproperty
	a_collide_sets: assert property (p_collide_sets) else $error("collide flag not set");
	property p_status_unmasked;
		s_evt_rd(i_evt.rx_ring_overflow, nicer_pkg::OFS_IRQ_STATUS_LO) |=> o_rd_data[4];
	endproperty
	a_status_unmasked: assert property (p_status_unmasked) else $error("status bit lost");
	property p_bus_rst;
		$past(i_rst) |-> !o_ctl.rx_enable && !o_ctl.tx_enable;
	endproperty
	a_bus_rst: assert property (p_bus_rst) else $error("enable survived reset");
	property p_mask_rst;
		$past(i_rst) |-> !o_irq ##1 !o_irq;
	endproperty
	a_mask_rst: assert property (p_mask_rst) else $error("irq with cleared mask");
	property p_rx_start;
		s_cmd ##0 (i_wr_data[3] && !i_wr_data[4] && i_rx_machine_idle && !o_ctl.sw_reset) |=> o_ctl.rx_enable;
	endproperty
	a_rx_start: assert property (p_rx_start) else $error("receiver not started");
	property p_sw_rst;
		s_cmd ##0 i_wr_data[4] |=> o_ctl.sw_reset && !o_ctl.rx_enable && !o_ctl.tx_enable;
	endproperty
	a_sw_rst: assert property (p_sw_rst) else $error("soft reset not entered");
	property p_sw_len;
		$fell(o_ctl.sw_reset) |-> int'(run_q) == RST_CYCLES;
	endproperty
	a_sw_len: assert property (p_sw_len) else $error("soft reset wrong length");
endmodule : nicer_chk

// >>> test/nicer_host.sv
// host driver model: byte-wide register master
`timescale 1ns/10ps
module nicer_host (
	input wire logic i_core_clk,
	input wire logic [7:0] i_rd_data,
	output logic [7:0] o_addr,
	output logic [7:0] o_wr_data,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 8'h00;
		o_wr_data = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// strobe drops at the next edge, so calls never collide; address is scrambled when idle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_wr_data <= d;
		o_wr <= 1'b1;
		@(posedge i_core_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_core_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_core_clk);
		d = i_rd_data;
	endtask : rd
	// software polls the reset bit before enabling the machines
	task automatic wait_rst_done(output logic ok);
		logic [7:0] d;
		ok = 1'b0;
		repeat (20) if (!ok) begin
			rd(nicer_pkg::OFS_COMMAND_CONTROL, d);
			ok = (d[4] === 1'b0);
		end
	endtask : wait_rst_done
endmodule : nicer_host

// >>> test/tb_nicer_regs.sv
// testbench: register bank driven by the host model
`timescale 1ns/10ps
module tb_nicer_regs;
	localparam logic [7:0] A_ERS = nicer_pkg::OFS_EARLY_RX_STATUS;
	localparam logic [7:0] A_CMD = nicer_pkg::OFS_COMMAND_CONTROL;
	localparam logic [7:0] A_MLO = nicer_pkg::OFS_IRQ_MASK_LO;
	localparam logic [7:0] A_SLO = nicer_pkg::OFS_IRQ_STATUS_LO;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] addr, wdata, rdata, d;
	logic wr, rd, irq, in_pkt = 1'b0, empty = 1'b0, rx_idle = 1'b1, tx_idle = 1'b1;
	nicer_pkg::nicer_evt_t evt = '0;
	nicer_pkg::nicer_ctl_t ctl;
	logic [10:0] cnt = 11'h040;
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	always #5 i_core_clk = ~i_core_clk;
	nicer_host u_host (.i_core_clk(i_core_clk), .i_rd_data(rdata), .o_addr(addr), .o_wr_data(wdata), .o_wr(wr),
		.o_rd(rd));
	nicer_regs #(.RST_CYCLES(4)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(ce), .i_addr(addr),
		.i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_evt(evt), .i_rx_byte_cnt(cnt),
		.i_rx_threshold(11'h040), .i_rx_in_packet(in_pkt), .i_rx_ring_empty(empty), .i_rx_machine_idle(rx_idle),
		.i_tx_machine_idle(tx_idle), .o_ctl(ctl), .o_irq(irq));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		u_host.rd(a, d);
		chk({8'h00, d}, {8'h00, exp});
	endtask : rchk
	task automatic pulse(input logic [10:0] e);
		@(posedge i_core_clk);
		evt <= e;
		@(posedge i_core_clk);
		evt <= '0;
	endtask : pulse
	task automatic t_ers;
		pulse(11'h004);
		rchk(A_ERS, 8'h08);
		pulse(11'h002);
		pulse(11'h001);
		rchk(A_ERS, 8'h0E);
		u_host.wr(A_ERS, 8'h0E);
		rchk(A_ERS, 8'h00);
		rchk(A_SLO, 8'h03);
		in_pkt <= 1'b1;
		rchk(A_ERS, 8'h00);
		cnt <= 11'h041;
		rchk(A_ERS, 8'h01);
		rchk(A_SLO, 8'h01);
		pulse(11'h004);
		in_pkt <= 1'b0;
		rchk(A_ERS, 8'h08);
		rchk(A_SLO, 8'h01);
		$display("early rx test done");
	endtask : t_ers
	task automatic t_irq;
		int sb[10] = '{1, 0, 2, 3, 4, 5, 6, 13, 14, 15};
		logic [7:0] lo, hi;
		u_host.wr(A_MLO, 8'hFF);
		u_host.wr(A_MLO + 8'h01, 8'hFF);
		rchk(A_MLO, 8'h7F);
		rchk(A_MLO + 8'h01, 8'hE0);
		for (int m = 0; m < 2; m++) begin
			u_host.wr(A_MLO, m ? 8'hFF : 8'h00);
			u_host.wr(A_MLO + 8'h01, m ? 8'hFF : 8'h00);
			for (int k = 1; k <= 10; k++) begin
				pulse(11'h001 << k);
				// the ignored status write also spaces the interrupt check two edges after the event
				u_host.wr(A_SLO, 8'h00);
				#1 chk({15'h0, irq}, m[15:0]);
				u_host.rd(A_SLO, lo);
				u_host.rd(A_SLO + 8'h01, hi);
				chk({hi, lo}, 16'h0001 << sb[k-1]);
				chk({15'h0, irq}, 16'h0000);
			end
		end
		$display("irq test done");
	endtask : t_irq
	task automatic t_cmd;
		logic ok;
		empty <= 1'b1;
		rx_idle <= 1'b0;
		u_host.wr(A_CMD, 8'h0C);
		rchk(A_CMD, 8'h05);
		rx_idle <= 1'b1;
		u_host.wr(A_CMD, 8'h0C);
		rchk(A_CMD, 8'h0D);
		u_host.wr(A_CMD, 8'h10);
		#1 chk({13'h0, ctl}, 16'h0004);
		rchk(A_CMD, 8'h11);
		u_host.wait_rst_done(ok);
		chk({15'h0, ok}, 16'h0001);
		rchk(A_CMD, 8'h01);
		rchk(A_MLO, 8'h7F);
		u_host.wr(A_CMD, 8'h0C);
		@(posedge i_core_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rchk(A_CMD, 8'h01);
		rchk(A_MLO, 8'h00);
		// with the clock enable low, a mask write must be ignored
		@(posedge i_core_clk);
		ce <= 1'b0;
		u_host.wr(A_MLO, 8'h01);
		ce <= 1'b1;
		rchk(A_MLO, 8'h00);
		$display("command test done");
	endtask : t_cmd
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	// hang guard, about sixteen times the expected run
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rst <= 1'b0;
		rchk(A_MLO, 8'h00);
		rchk(A_CMD, 8'h00);
		rchk(8'h50, 8'h00);
		t_ers;
		t_irq;
		t_cmd;
		test_done;
	end
endmodule : tb_nicer_regs
bind nicer_regs nicer_chk #(.RST_CYCLES(RST_CYCLES)) u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_evt(i_evt),
	.i_rx_machine_idle(i_rx_machine_idle), .o_ctl(o_ctl), .o_irq(o_irq));
